// ### hdl/iopc_io_pin_controller.sv
// Pin controller for one 32-pin port: ownership, muxing, pads and interrupts
//
// Local design decisions: the address map and the plain strobed port.
module iopc_io_pin_controller
    import iopc_pkg::*;
#(
    parameter logic [31:0] PIN_PRESENT = 32'hFFFF_FFFF,
    parameter logic [31:0] OWN_RESET = IOPC_OWN_RST,
    parameter logic [31:0] PERIPH_PULL_SUP = 32'h0000_0000,
    parameter logic [31:0] PERIPH_DRV_SUP = 32'h0000_0000
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [IOPC_AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [31:0] io_pin_in,
    output logic [31:0] io_pin_out,
    output logic [31:0] io_pin_oe_n,
    output logic [31:0] io_pin_pullup,
    output logic [31:0] io_pin_pulldown,
    output logic [31:0] io_pin_drv0,
    output logic [31:0] io_pin_drv1,
    output logic [1:0] periph_fsel [32],
    output logic [31:0] periph_in,
    input wire logic [31:0] periph_out [4],
    input wire logic [31:0] periph_oe [4],
    input wire logic [31:0] periph_pullup [4],
    input wire logic [31:0] periph_pulldown [4],
    input wire logic [31:0] periph_drv0 [4],
    input wire logic [31:0] periph_drv1 [4],
    output logic [3:0] irq_group
);

    ////////////////////////////////////////////////////////////////////////
    // Register storage

    logic [31:0] own_reg, fsel0_reg, fsel1_reg, ode_reg, olv_reg;
    logic [31:0] pue_reg, pde_reg, ien_reg, im0_reg, im1_reg, gfe_reg;
    logic [31:0] ds0_reg, ds1_reg, flag_reg, plv_reg;
    logic [31:0] rdata_reg;
    logic [31:0] sync_reg, filt_a_reg, filt_b_reg, filt_c_reg, prev_reg;

    // Bit update for a word/set/clear/toggle access, unused pins stay zero
    function automatic logic [31:0] acc_apply(input logic [31:0] cur,
                                              input logic [3:0] kind,
                                              input logic [31:0] wd);
        logic [31:0] r;
        r = cur;
        case (kind)
            IOPC_ACC_WR: r = wd;
            IOPC_ACC_SET: r = cur | wd;
            IOPC_ACC_CLR: r = cur & ~wd;
            IOPC_ACC_TGL: r = cur ^ wd;
            default: r = cur;
        endcase
        return r & PIN_PRESENT;
    endfunction

    // Address decode: upper nibble picks register, lower the access kind
    function automatic logic hit(input logic [IOPC_AW-1:0] a,
                                 input logic [7:0] ofs);
        return a[7:4] == ofs[7:4];
    endfunction

    // Offsets that match no register decode to nothing, so such
    // writes fall away and reads of them return zero
    wire [3:0] acc_kind = reg_addr[3:0];
    wire wr_own = reg_wr && hit(reg_addr, IOPC_OWN_OFS);
    wire wr_fs0 = reg_wr && hit(reg_addr, IOPC_FSEL0_OFS);
    wire wr_fs1 = reg_wr && hit(reg_addr, IOPC_FSEL1_OFS);
    wire wr_ode = reg_wr && hit(reg_addr, IOPC_ODE_OFS);
    wire wr_olv = reg_wr && hit(reg_addr, IOPC_OLV_OFS);
    wire wr_pue = reg_wr && hit(reg_addr, IOPC_PUE_OFS);
    wire wr_pde = reg_wr && hit(reg_addr, IOPC_PDE_OFS);
    wire wr_ien = reg_wr && hit(reg_addr, IOPC_IEN_OFS);
    wire wr_im0 = reg_wr && hit(reg_addr, IOPC_IM0_OFS);
    wire wr_im1 = reg_wr && hit(reg_addr, IOPC_IM1_OFS);
    wire wr_gfe = reg_wr && hit(reg_addr, IOPC_GFE_OFS);
    wire wr_ds0 = reg_wr && hit(reg_addr, IOPC_DS0_OFS);
    wire wr_ds1 = reg_wr && hit(reg_addr, IOPC_DS1_OFS);
    // Flag register only takes the clear access
    wire wr_flag = reg_wr && hit(reg_addr, IOPC_FLAG_OFS)
                   && acc_kind == IOPC_ACC_CLR;

    // Configuration registers; only advance on clk edges, so stopping
    // the clock simply freezes them
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            // Pins start owned and undriven, so no pad glitches at reset
            own_reg <= OWN_RESET & PIN_PRESENT;
            fsel0_reg <= IOPC_ZERO_RST;
            fsel1_reg <= IOPC_ZERO_RST;
            ode_reg <= IOPC_ZERO_RST;
            olv_reg <= IOPC_ZERO_RST;
            pue_reg <= IOPC_ZERO_RST;
            pde_reg <= IOPC_ZERO_RST;
            ien_reg <= IOPC_ZERO_RST;
            im0_reg <= IOPC_ZERO_RST;
            im1_reg <= IOPC_ZERO_RST;
            gfe_reg <= IOPC_ZERO_RST;
            ds0_reg <= IOPC_ZERO_RST;
            ds1_reg <= IOPC_ZERO_RST;
        end else begin
            if (wr_own) own_reg <= acc_apply(own_reg, acc_kind, reg_wdata);
            if (wr_fs0) fsel0_reg <= acc_apply(fsel0_reg, acc_kind, reg_wdata);
            if (wr_fs1) fsel1_reg <= acc_apply(fsel1_reg, acc_kind, reg_wdata);
            if (wr_ode) ode_reg <= acc_apply(ode_reg, acc_kind, reg_wdata);
            if (wr_olv) olv_reg <= acc_apply(olv_reg, acc_kind, reg_wdata);
            if (wr_pue) pue_reg <= acc_apply(pue_reg, acc_kind, reg_wdata);
            if (wr_pde) pde_reg <= acc_apply(pde_reg, acc_kind, reg_wdata);
            if (wr_ien) ien_reg <= acc_apply(ien_reg, acc_kind, reg_wdata);
            if (wr_im0) im0_reg <= acc_apply(im0_reg, acc_kind, reg_wdata);
            if (wr_im1) im1_reg <= acc_apply(im1_reg, acc_kind, reg_wdata);
            if (wr_gfe) gfe_reg <= acc_apply(gfe_reg, acc_kind, reg_wdata);
            if (wr_ds0) ds0_reg <= acc_apply(ds0_reg, acc_kind, reg_wdata);
            if (wr_ds1) ds1_reg <= acc_apply(ds1_reg, acc_kind, reg_wdata);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pad multiplexing, purely combinational so peripherals keep their
    // pins while the clock is stopped

    logic [31:0] per_out, per_oe, per_pu, per_pd, per_d0, per_d1;
    genvar gi;
    generate
        for (gi = 0; gi < IOPC_PINS; gi++) begin : g_mux
            wire [1:0] fn = {fsel1_reg[gi], fsel0_reg[gi]};
            assign periph_fsel[gi] = fn;
            assign per_out[gi] = periph_out[fn][gi];
            assign per_oe[gi] = periph_oe[fn][gi];
            assign per_pu[gi] = periph_pullup[fn][gi];
            assign per_pd[gi] = periph_pulldown[fn][gi];
            assign per_d0[gi] = periph_drv0[fn][gi];
            assign per_d1[gi] = periph_drv1[fn][gi];
        end
    endgenerate

    // Owned pins follow the registers; others follow the peripheral
    wire [31:0] pmode = ~own_reg & PIN_PRESENT;
    wire [31:0] drive_en = (own_reg & ode_reg)
                           | (pmode & per_oe);
    assign io_pin_out = (own_reg & olv_reg) | (pmode & per_out);
    assign io_pin_oe_n = ~(drive_en & PIN_PRESENT);
    // Pad features fall back to registers where peripheral lacks support
    wire [31:0] pull_sel = pmode & PERIPH_PULL_SUP;
    wire [31:0] drv_sel = pmode & PERIPH_DRV_SUP;
    assign io_pin_pullup = ((pull_sel & per_pu) | (~pull_sel & pue_reg))
                           & PIN_PRESENT;
    assign io_pin_pulldown = ((pull_sel & per_pd) | (~pull_sel & pde_reg))
                             & PIN_PRESENT;
    assign io_pin_drv0 = ((drv_sel & per_d0) | (~drv_sel & ds0_reg))
                         & PIN_PRESENT;
    assign io_pin_drv1 = ((drv_sel & per_d1) | (~drv_sel & ds1_reg))
                         & PIN_PRESENT;
    // Peripheral inputs see the raw pin, never the filter
    assign periph_in = io_pin_in & pmode;

    ////////////////////////////////////////////////////////////////////////
    // Pin level capture and interrupt detection

    wire [31:0] plv_upd = (own_reg | ien_reg) & PIN_PRESENT;
    // Filter: a level counts once two successive samples agree; the
    // extra stages cost two cycles over the plain path, the price of
    // keeping pulses seen on a single edge away from the flags
    wire [31:0] filt_agree = ~(filt_b_reg ^ filt_c_reg);
    wire [31:0] det_in = (gfe_reg & ((filt_agree & filt_c_reg)
                         | (~filt_agree & prev_reg)))
                         | (~gfe_reg & sync_reg);
    wire [31:0] rise = det_in & ~prev_reg;
    wire [31:0] fall = ~det_in & prev_reg;
    logic [31:0] evt;
    always_comb begin
        for (int i = 0; i < IOPC_PINS; i++) begin
            case ({im1_reg[i], im0_reg[i]})
                IOPC_IM_CHANGE: evt[i] = rise[i] | fall[i];
                IOPC_IM_RISE: evt[i] = rise[i];
                IOPC_IM_FALL: evt[i] = fall[i];
                default: evt[i] = rise[i] | fall[i];
            endcase
        end
    end
    wire [31:0] evt_en = evt & ien_reg & PIN_PRESENT;

    // Level registers; the pin level register follows the pin only where it is owned or interrupt-enabled, else holds
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            plv_reg <= IOPC_ZERO_RST;
            sync_reg <= IOPC_ZERO_RST;
            filt_a_reg <= IOPC_ZERO_RST;
            filt_b_reg <= IOPC_ZERO_RST;
            filt_c_reg <= IOPC_ZERO_RST;
            prev_reg <= IOPC_ZERO_RST;
            flag_reg <= IOPC_ZERO_RST;
        end else begin
            plv_reg <= (plv_upd & io_pin_in) | (~plv_upd & plv_reg);
            sync_reg <= io_pin_in;
            filt_a_reg <= io_pin_in;
            filt_b_reg <= filt_a_reg;
            filt_c_reg <= filt_b_reg;
            prev_reg <= det_in;
            // A new event wins over a clear in the same cycle
            flag_reg <= ((wr_flag ? flag_reg & ~reg_wdata : flag_reg)
                        | evt_en) & PIN_PRESENT;
        end
    end

    // One request line per group of eight pins
    generate
        for (gi = 0; gi < IOPC_PINS / IOPC_GROUP; gi++) begin : g_irq
            assign irq_group[gi] = |(flag_reg[gi*IOPC_GROUP +: IOPC_GROUP]
                                    & ien_reg[gi*IOPC_GROUP +: IOPC_GROUP]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Read port: data stands the cycle after the strobe, else zero

    logic [31:0] rd_mux;
    always_comb begin
        case (reg_addr[7:4])
            IOPC_OWN_OFS[7:4]: rd_mux = own_reg;
            IOPC_FSEL0_OFS[7:4]: rd_mux = fsel0_reg;
            IOPC_FSEL1_OFS[7:4]: rd_mux = fsel1_reg;
            IOPC_ODE_OFS[7:4]: rd_mux = ode_reg;
            IOPC_OLV_OFS[7:4]: rd_mux = olv_reg;
            IOPC_PLV_OFS[7:4]: rd_mux = plv_reg;
            IOPC_PUE_OFS[7:4]: rd_mux = pue_reg;
            IOPC_PDE_OFS[7:4]: rd_mux = pde_reg;
            IOPC_IEN_OFS[7:4]: rd_mux = ien_reg;
            IOPC_IM0_OFS[7:4]: rd_mux = im0_reg;
            IOPC_IM1_OFS[7:4]: rd_mux = im1_reg;
            IOPC_GFE_OFS[7:4]: rd_mux = gfe_reg;
            IOPC_FLAG_OFS[7:4]: rd_mux = flag_reg;
            IOPC_DS0_OFS[7:4]: rd_mux = ds0_reg;
            IOPC_DS1_OFS[7:4]: rd_mux = ds1_reg;
            default: rd_mux = IOPC_ZERO_RST;
        endcase
    end
    always_ff @(posedge clk) begin
        if (sys_rst) rdata_reg <= IOPC_ZERO_RST;
        else rdata_reg <= (reg_rd && reg_addr[3:0] == IOPC_ACC_WR)
                          ? rd_mux : IOPC_ZERO_RST;
    end
    assign reg_rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    // Owned pin: pad follows the drive enable and level registers
    chk_owned_drive: assert property (
        @(posedge clk) disable iff (sys_rst)
        own_reg[0] |-> (io_pin_oe_n[0] == !ode_reg[0])
                       && (io_pin_out[0] == olv_reg[0]))
        else $error("owned pin drive mismatch");

    // Owned pin: pulls come from the controller's own registers
    chk_owned_pulls: assert property (
        @(posedge clk) disable iff (sys_rst)
        own_reg[0] |-> (io_pin_pullup[0] == pue_reg[0])
                       && (io_pin_pulldown[0] == pde_reg[0]))
        else $error("owned pin pull mismatch");

    // Owned pin: drive strength from the strength registers
    chk_owned_strength: assert property (
        @(posedge clk) disable iff (sys_rst)
        own_reg[0] |-> (io_pin_drv0[0] == ds0_reg[0])
                       && (io_pin_drv1[0] == ds1_reg[0]))
        else $error("owned pin strength mismatch");

    // Released pin: the selected function supplies the level
    chk_periph_drive: assert property (
        @(posedge clk) disable iff (sys_rst)
        !own_reg[0] |-> io_pin_out[0] == periph_out[periph_fsel[0]][0])
        else $error("peripheral output mismatch");

    // Released pin: the selected function decides the drive
    chk_periph_enable: assert property (
        @(posedge clk) disable iff (sys_rst)
        !own_reg[0] |-> io_pin_oe_n[0] == !periph_oe[periph_fsel[0]][0])
        else $error("peripheral enable mismatch");

    // Peripherals see the raw pin, and nothing while the pin is owned
    chk_periph_raw_in: assert property (
        @(posedge clk) disable iff (sys_rst)
        periph_in[0] == (io_pin_in[0] & !own_reg[0]))
        else $error("peripheral input mismatch");

    // Function number built from the two planes, plane zero lowest
    chk_fsel_number: assert property (
        @(posedge clk) disable iff (sys_rst)
        periph_fsel[4] == {fsel1_reg[4], fsel0_reg[4]})
        else $error("function number mismatch");

    // Set access only raises the written bits
    chk_set_access: assert property (
        @(posedge clk) disable iff (sys_rst)
        (reg_wr && reg_addr == (IOPC_OLV_OFS | 8'h04))
        |=> olv_reg == ($past(olv_reg) | $past(reg_wdata)))
        else $error("set access wrong");

    // Toggle access only flips the written bits
    chk_toggle_access: assert property (
        @(posedge clk) disable iff (sys_rst)
        (reg_wr && reg_addr == (IOPC_OLV_OFS | 8'h0C))
        |=> olv_reg == ($past(olv_reg) ^ $past(reg_wdata)))
        else $error("toggle access wrong");

    // Reads through a set, clear or toggle slot give zero
    chk_read_refused: assert property (
        @(posedge clk) disable iff (sys_rst)
        (reg_rd && reg_addr[3:0] != IOPC_ACC_WR)
        |=> reg_rdata == IOPC_ZERO_RST)
        else $error("read at access slot not zero");

    // Gated pin level keeps its old value to save power
    chk_level_hold: assert property (
        @(posedge clk) disable iff (sys_rst)
        (!own_reg[1] && !ien_reg[1]) |=> $stable(plv_reg[1]))
        else $error("pin level changed while gated");

    // Owned pin level follows the pad one cycle later
    chk_level_track: assert property (
        @(posedge clk) disable iff (sys_rst)
        own_reg[2] |=> plv_reg[2] == $past(io_pin_in[2]))
        else $error("pin level not tracked");

    // Unfiltered rising edge in rise mode sets the flag
    chk_rise_flag: assert property (
        @(posedge clk) disable iff (sys_rst)
        (ien_reg[20] && !gfe_reg[20] && im0_reg[20] && !im1_reg[20]
         && sync_reg[20] && !prev_reg[20]) |=> flag_reg[20])
        else $error("rising event lost");

    // Unfiltered falling edge in fall mode sets the flag
    chk_fall_flag: assert property (
        @(posedge clk) disable iff (sys_rst)
        (ien_reg[20] && !gfe_reg[20] && !im0_reg[20] && im1_reg[20]
         && !sync_reg[20] && prev_reg[20]) |=> flag_reg[20])
        else $error("falling event lost");

    // An event beats a clear that lands in the same cycle
    chk_event_wins: assert property (
        @(posedge clk) disable iff (sys_rst)
        (evt_en[20] && wr_flag && reg_wdata[20]) |=> flag_reg[20])
        else $error("event lost to clear");

    // While the samples disagree the detector holds its level
    chk_glitch_drop: assert property (
        @(posedge clk) disable iff (sys_rst)
        (gfe_reg[20] && filt_b_reg[20] != filt_c_reg[20])
        |-> det_in[20] == prev_reg[20])
        else $error("glitch passed filter");

    // A group request needs an enabled flag in its group
    chk_group_irq: assert property (
        @(posedge clk) disable iff (sys_rst)
        irq_group[2] |-> |(flag_reg[23:16] & ien_reg[23:16]))
        else $error("group irq without cause");

    // An enabled flag always reaches its group line
    chk_group_cause: assert property (
        @(posedge clk) disable iff (sys_rst)
        (flag_reg[20] && ien_reg[20]) |-> irq_group[2])
        else $error("group irq missing");
endmodule

// ### hdl/iopc_pkg.sv
// Package: register offsets, layout and reset values of the pin controller
package iopc_pkg;
    localparam int IOPC_PINS = 32;
    localparam int IOPC_PLANES = 2;
    localparam int IOPC_AW = 8;
    // Register word offsets (byte addresses); each writable one has +4 set,
    // +8 clear and +C toggle beside the plain word slot (flag: +8 clear only, pin level: none)
    localparam logic [7:0] IOPC_OWN_OFS = 8'h00;
    localparam logic [7:0] IOPC_FSEL0_OFS = 8'h10;
    localparam logic [7:0] IOPC_FSEL1_OFS = 8'h20;
    localparam logic [7:0] IOPC_ODE_OFS = 8'h40;
    localparam logic [7:0] IOPC_OLV_OFS = 8'h50;
    localparam logic [7:0] IOPC_PLV_OFS = 8'h60;
    localparam logic [7:0] IOPC_PUE_OFS = 8'h70;
    localparam logic [7:0] IOPC_PDE_OFS = 8'h80;
    localparam logic [7:0] IOPC_IEN_OFS = 8'h90;
    localparam logic [7:0] IOPC_IM0_OFS = 8'hA0;
    localparam logic [7:0] IOPC_IM1_OFS = 8'hB0;
    localparam logic [7:0] IOPC_GFE_OFS = 8'hC0;
    localparam logic [7:0] IOPC_FLAG_OFS = 8'hD0;
    localparam logic [7:0] IOPC_DS0_OFS = 8'h30;
    localparam logic [7:0] IOPC_DS1_OFS = 8'hF0;
    // Access kinds in the low nibble
    localparam logic [3:0] IOPC_ACC_WR = 4'h0;
    localparam logic [3:0] IOPC_ACC_SET = 4'h4;
    localparam logic [3:0] IOPC_ACC_CLR = 4'h8;
    localparam logic [3:0] IOPC_ACC_TGL = 4'hC;
    // Reset values
    localparam logic [31:0] IOPC_OWN_RST = 32'hFFFF_FFFF;
    localparam logic [31:0] IOPC_ZERO_RST = 32'h0000_0000;
    // Interrupt mode codes: {im1,im0}
    localparam logic [1:0] IOPC_IM_CHANGE = 2'h0;
    localparam logic [1:0] IOPC_IM_RISE = 2'h1;
    localparam logic [1:0] IOPC_IM_FALL = 2'h2;
    localparam int IOPC_GROUP = 8;
endpackage

// ### verif/iopc_pad_model.sv
// Pad model: resolves each pin from controller, outside driver and pulls
module iopc_pad_model (
    input wire logic clk,
    input wire logic [31:0] io_pin_out,
    input wire logic [31:0] io_pin_oe_n,
    input wire logic [31:0] io_pin_pullup,
    input wire logic [31:0] io_pin_pulldown,
    input wire logic [31:0] ext_drv,
    input wire logic [31:0] ext_val,
    output logic [31:0] io_pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] last_reg = 32'h0000_0000;
    logic [31:0] dut_on;
    logic [31:0] lvl;
    // Undriven, unpulled pins wander instead of keeping a stale value
    assign dut_on = ~io_pin_oe_n;
    assign lvl = (dut_on & io_pin_out) | (~dut_on & ext_drv & ext_val)
        | (~dut_on & ~ext_drv
           & (io_pin_pullup | (~io_pin_pulldown & ~last_reg)));
    // Two drivers on one pin give an unknown level
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            io_pin_in[i] = (dut_on[i] & ext_drv[i]) ? 1'bx : lvl[i];
        end
    end
    // Floating pins swap level each clock; a clash on one pin must not
    // leave an unknown behind in this state
    always_ff @(posedge clk) begin
        last_reg <= ~last_reg;
    end
endmodule

// ### verif/tb.sv
// Self-checking bench for the pin controller
module tb
    import iopc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] PULL_SUP = 32'h00FF_00FF;
    localparam logic [31:0] DRV_SUP = 32'h0F0F_0F0F;
    localparam logic [31:0] FS0 = 32'h0000_AAAA;
    localparam logic [31:0] FS1 = 32'h0000_CCCC;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic rd_pend = 1'b0;
    logic [31:0] reg_rdata, io_pin_in, io_pin_out, io_pin_oe_n, periph_in;
    logic [31:0] pu, pd, d0, d1;
    logic [31:0] ext_drv = 32'h0000_0000;
    logic [31:0] ext_val = 32'h0000_0000;
    logic [1:0] periph_fsel [32];
    logic [31:0] p_out [4], p_oe [4], p_pu [4], p_pd [4], p_d0 [4], p_d1 [4];
    logic [3:0] irq_group;
    logic [31:0] exp_q [$];
    logic [31:0] a, b, c, v, w, ue, de, dr, eo, eoe, epu, epd, ed0, ed1, ein;
    logic [1:0] fn;
    logic own;
    int num_errors = 0;
    int samples_checked = 0;

    // One clock for bus and pins, as the local bus needs
    always #12.5 clk = ~clk;

    iopc_io_pin_controller #(.PERIPH_PULL_SUP(PULL_SUP),
        .PERIPH_DRV_SUP(DRV_SUP)) dut (.clk(clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .io_pin_in(io_pin_in),
        .io_pin_out(io_pin_out), .io_pin_oe_n(io_pin_oe_n),
        .io_pin_pullup(pu), .io_pin_pulldown(pd), .io_pin_drv0(d0),
        .io_pin_drv1(d1), .periph_fsel(periph_fsel), .periph_in(periph_in),
        .periph_out(p_out), .periph_oe(p_oe), .periph_pullup(p_pu),
        .periph_pulldown(p_pd), .periph_drv0(p_d0), .periph_drv1(p_d1),
        .irq_group(irq_group));

    iopc_pad_model pads (.clk(clk), .io_pin_out(io_pin_out),
        .io_pin_oe_n(io_pin_oe_n), .io_pin_pullup(pu), .io_pin_pulldown(pd),
        .ext_drv(ext_drv), .ext_val(ext_val), .io_pin_in(io_pin_in));

    task automatic chk(input logic [31:0] got, input logic [31:0] e,
                       input string what);
        samples_checked++;
        if (got !== e) begin
            num_errors++;
            $display("Error at %0t: %s got %h exp %h", $time, what, got, e);
        end
    endtask

    // One bus cycle; the strobe drops an edge later so calls never collide
    task automatic bus(input logic [7:0] ad, input logic [31:0] dt,
                       input logic wr);
        @(posedge clk);
        reg_addr <= ad;
        reg_wdata <= dt;
        reg_wr <= wr;
        reg_rd <= ~wr;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] ad, input logic [31:0] e);
        exp_q.push_back(e);
        bus(ad, 32'h0000_0000, 1'b0);
    endtask

    // Lets pin and register effects settle before looking
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic irq_step(input logic lvl, input logic e);
        @(posedge clk);
        ext_val[20] <= lvl;
        wt(6);
        chk({28'h0, irq_group}, e ? 32'h4 : 32'h0, "group request");
        bus(IOPC_FLAG_OFS | IOPC_ACC_CLR, 32'hFFFF_FFFF, 1'b1);
    endtask

    task automatic done_t(input string s);
        $display("test %s done, errors so far %0d", s, num_errors);
    endtask

    task automatic close_out();
        $display("comparisons %0d, errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_pend) begin
            chk(reg_rdata, exp_q.pop_front(), "read data");
        end
        rd_pend <= reg_rd;
    end

    // Cuts a hang short; the run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        close_out();
    end

    initial begin
        for (int f = 0; f < 4; f++) begin
            {p_out[f], p_oe[f], p_pu[f], p_pd[f], p_d0[f], p_d1[f]} = '0;
        end
        void'($urandom(93798));
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        rd(IOPC_OWN_OFS, IOPC_OWN_RST);
        rd(IOPC_ODE_OFS, IOPC_ZERO_RST);
        wt(0);
        chk(io_pin_oe_n, 32'hFFFF_FFFF, "enable after reset");
        done_t("reset");
        // Word, set, clear and toggle in turn, each read back
        for (int k = 0; k < 4; k++) begin
            w = $urandom;
            bus(IOPC_OLV_OFS | 8'(4 * k), w, 1'b1);
            v = (k == 0) ? w : (k == 1) ? (v | w)
                : (k == 2) ? (v & ~w) : (v ^ w);
            rd(IOPC_OLV_OFS, v);
        end
        rd(8'hE0, 32'h0000_0000);
        rd(IOPC_OLV_OFS | IOPC_ACC_SET, 32'h0000_0000);
        done_t("access kinds");
        a = $urandom;
        b = $urandom;
        c = $urandom;
        ue = $urandom;
        de = $urandom;
        dr = $urandom;
        bus(IOPC_ODE_OFS, a, 1'b1);
        bus(IOPC_OLV_OFS, b, 1'b1);
        bus(IOPC_PUE_OFS, ue, 1'b1);
        bus(IOPC_PDE_OFS, de, 1'b1);
        bus(IOPC_DS1_OFS, dr, 1'b1);
        bus(IOPC_DS0_OFS, ~dr, 1'b1);
        ext_drv <= ~a;
        ext_val <= c;
        wt(3);
        chk(io_pin_out, b, "driven level");
        chk(io_pin_oe_n, ~a, "drive enable");
        chk(pu, ue, "pull-up");
        chk(pd, de, "pull-down");
        chk(d1, dr, "drive strength");
        chk(d0, ~dr, "drive strength 0");
        rd(IOPC_PLV_OFS, (a & b) | (~a & c));
        done_t("owned pins");
        // Released pins without interrupt enable keep their old level
        bus(IOPC_ODE_OFS, 32'h0000_0000, 1'b1);
        ext_drv <= 32'hFFFF_FFFF;
        ext_val <= c;
        bus(IOPC_IEN_OFS, 32'h0000_0100, 1'b1);
        bus(IOPC_OWN_OFS | IOPC_ACC_CLR, 32'h0000_FF00, 1'b1);
        w = ~c;
        ext_val <= w;
        wt(3);
        rd(IOPC_PLV_OFS, (c & 32'h0000_FE00) | (w & ~32'h0000_FE00));
        done_t("level refresh");
        bus(IOPC_IEN_OFS, 32'h0010_0000, 1'b1);
        irq_step(1'b0, ext_val[20]);
        for (int m = 0; m < 3; m++) begin
            bus(IOPC_IM0_OFS, 32'(m & 1) << 20, 1'b1);
            bus(IOPC_IM1_OFS, 32'(m >> 1) << 20, 1'b1);
            irq_step(1'b1, m != 2);
            irq_step(1'b0, m != 1);
        end
        // Both mode bits set reports every change as well
        bus(IOPC_IM0_OFS, 32'h0010_0000, 1'b1);
        irq_step(1'b1, 1'b1);
        irq_step(1'b0, 1'b1);
        bus(IOPC_IM1_OFS, 32'h0000_0000, 1'b1);
        bus(IOPC_GFE_OFS, 32'h0010_0000, 1'b1);
        irq_step(1'b1, 1'b1);
        irq_step(1'b0, 1'b0);
        // A pulse seen on one edge only must not reach the flag
        @(posedge clk);
        ext_val[20] <= 1'b1;
        @(posedge clk);
        ext_val[20] <= 1'b0;
        wt(6);
        chk({28'h0, irq_group}, 32'h0, "short pulse");
        done_t("interrupts");
        @(posedge clk);
        ext_drv <= 32'h0000_0000;
        for (int f = 0; f < 4; f++) begin
            {p_out[f], p_oe[f], p_pu[f]} <= {$urandom, $urandom, $urandom};
            {p_pd[f], p_d0[f], p_d1[f]} <= {$urandom, $urandom, $urandom};
        end
        bus(IOPC_OWN_OFS, 32'hFFFF_0000, 1'b1);
        bus(IOPC_FSEL0_OFS, FS0, 1'b1);
        bus(IOPC_FSEL1_OFS, FS1, 1'b1);
        bus(IOPC_ODE_OFS, a, 1'b1);
        wt(2);
        for (int i = 0; i < 32; i++) begin
            fn = {FS1[i], FS0[i]};
            own = i > 15;
            eo[i] = own ? b[i] : p_out[fn][i];
            eoe[i] = own ? ~a[i] : ~p_oe[fn][i];
            epu[i] = (!own && PULL_SUP[i]) ? p_pu[fn][i] : ue[i];
            epd[i] = (!own && PULL_SUP[i]) ? p_pd[fn][i] : de[i];
            ed0[i] = (!own && DRV_SUP[i]) ? p_d0[fn][i] : ~dr[i];
            ed1[i] = (!own && DRV_SUP[i]) ? p_d1[fn][i] : dr[i];
            ein[i] = own ? 1'b0 : io_pin_in[i];
            if (!own) begin
                chk({30'h0, periph_fsel[i]}, {30'h0, fn}, "select");
            end
        end
        chk(io_pin_out, eo, "muxed level");
        chk(io_pin_oe_n, eoe, "muxed enable");
        chk(pu, epu, "muxed pull-up");
        chk(pd, epd, "muxed pull-down");
        chk(d0, ed0, "muxed drive 0");
        chk(d1, ed1, "muxed drive 1");
        chk(periph_in, ein, "peripheral input");
        done_t("peripheral mode");
        close_out();
    end
endmodule
